// ===== common/cebi_pkg.sv
// Purpose: shared constants and types for the external bus host controller
// Assumes: one core clock at 200 MHz, all bus pins sampled on that clock
// Notes:   the host plays memory slave, arbiter, alternate master and irq source
package cebi_pkg;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CORE_NS  = 5;
    localparam int BCLK_NS  = 40;
    localparam int BCLK_CYC = BCLK_NS / CORE_NS;
    localparam int DIV_W    = $clog2(BCLK_CYC);
    localparam int WAIT_BEATS = 1;
    localparam int ALT_BEATS  = 2;
    localparam int LINE_BEATS = 4;
    localparam int MEM_AW     = 10;

    // ---------------------------------------------------------------
    // encodings and address regions
    // ---------------------------------------------------------------
    localparam logic [1:0] CLS_NORMAL = 2'h0;
    localparam logic [1:0] CLS_MOVE   = 2'h1;
    localparam logic [1:0] CLS_ALT    = 2'h2;
    localparam logic [1:0] CLS_ACK    = 2'h3;
    localparam logic [1:0] SZ_LONG    = 2'h0;
    localparam logic [1:0] SZ_BYTE    = 2'h1;
    localparam logic [1:0] SZ_WORD    = 2'h2;
    localparam logic [1:0] SZ_LINE    = 2'h3;
    localparam int NOCACHE_BIT = 31;
    localparam int NOBURST_BIT = 30;

    typedef struct packed {
        logic [1:0] cls;
        logic [2:0] modifier;
        logic [1:0] line_idx;
        logic [1:0] user_attr;
        logic [1:0] size;
        logic       rd;
        logic       lock;
        logic       lock_last;
        logic       no_cache;
    } cebi_attr_s;

    typedef struct packed {
        logic [31:0] addr;
        logic [1:0]  op;
        logic        rd;
    } cebi_alt_s;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_WAIT = 4'h2,
        ST_RESP = 4'h4,
        ST_ALT  = 4'h8
    } cebi_state_e;

    // big-endian lanes: lane 3 is data bits 31..24
    function automatic logic [3:0] cebi_lanes(input logic [1:0] size, input logic [1:0] a);
        unique case (size)
            SZ_BYTE: cebi_lanes = 4'h8 >> a;
            SZ_WORD: cebi_lanes = a[1] ? 4'h3 : 4'hc;
            default: cebi_lanes = 4'hf;
        endcase
    endfunction

endpackage

// ===== logic/cebi_mem.sv
// Purpose: word memory behind the host slave, byte-lane writes
// Assumes: one access per cycle, read data registered
// Notes:   write and read may share a cycle; read returns old data
`timescale 1ns/1ps
module cebi_mem
    import cebi_pkg::*;
#(
    parameter int AW = MEM_AW
) (
    input  wire logic          core_clk,
    input  wire logic [AW-1:0] addr,
    input  wire logic          rd_en,
    input  wire logic          wr_en,
    input  wire logic [3:0]    lanes,
    input  wire logic [31:0]   wdata,
    output logic      [31:0]   rdata
);
    logic [31:0] mem [0:(1<<AW)-1];

    always_ff @(posedge core_clk) begin
        if (rd_en) begin
            rdata <= mem[addr];
        end
    end

    // one process only, so the array keeps a single writer
    always_ff @(posedge core_clk) begin
        for (int b = 0; b < 4; b++) begin
            if (wr_en && lanes[b]) begin
                mem[addr][8*b +: 8] <= wdata[8*b +: 8];
            end
        end
    end

endmodule

// ===== logic/cebi_host.sv
// Purpose: system-side partner of the processor bus: slave, arbiter, snoop master
// Assumes: processor pins are synchronous to core_clk, active high here except data_oe_n and owned_oe_n
// Notes:   bus decisions advance only on the bus clock enable pulse
`timescale 1ns/1ps
module cebi_host
    import cebi_pkg::*;
#(
    parameter int AW = MEM_AW
) (
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    output logic             pclk_out,
    output logic             bclk_out,
    input  wire logic [31:0] phys_addr_bus,
    input  wire cebi_attr_s  attr,
    input  wire logic        xfer_start,
    input  wire logic        xfer_active,
    input  wire logic [31:0] data_in,
    output logic      [31:0] data_out,
    output logic             data_oe_n,
    output logic             xfer_ack,
    output logic             xfer_err_ack,
    output logic             slave_no_cache,
    output logic             slave_no_burst,
    input  wire logic        dle_mode,
    output logic             read_latch_clk,
    input  wire logic        bus_req,
    output logic             bus_gnt,
    input  wire logic        owned_in,
    output logic             owned_out,
    output logic             owned_oe_n,
    output logic      [1:0]  snoop_op,
    output logic      [31:0] snoop_addr,
    output logic             alt_start,
    input  wire logic        mem_hold_off,
    input  wire logic        alt_req,
    input  wire cebi_alt_s   alt_cmd,
    input  wire logic [31:0] alt_wdata,
    output logic             alt_done,
    output logic             alt_inhibited,
    output logic      [31:0] alt_rdata,
    input  wire logic        cache_kill,
    input  wire logic        xlate_kill,
    output logic             caches_off,
    output logic             xlate_off,
    input  wire logic        sys_reset_req,
    output logic             cpu_reset_in,
    input  wire logic        ext_reset_out,
    output logic             periph_reset,
    input  wire logic [7:1]  irq_src,
    output logic      [2:0]  irq_level,
    input  wire logic        irq_waiting,
    output logic             irq_seen,
    input  wire logic        autovec_en,
    output logic             auto_vector_req
);
    // ---------------------------------------------------------------
    // clock divider
    // ---------------------------------------------------------------
    logic [DIV_W-1:0] div_cnt;
    logic             bclk_en;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + 1'b1;
        end
    end

    assign bclk_en  = (div_cnt == DIV_W'(BCLK_CYC - 1));
    assign pclk_out = div_cnt[DIV_W-2];
    assign bclk_out = div_cnt[DIV_W-1];

    // ---------------------------------------------------------------
    // transfer sequencer
    // ---------------------------------------------------------------
    cebi_state_e state;
    cebi_attr_s  cur;
    logic [31:0] cur_addr;
    logic [1:0]  wait_cnt;
    logic [1:0]  beats_left;
    logic [1:0]  alt_cnt;
    cebi_alt_s   alt_cur;
    logic [31:0] alt_wd;
    logic        lock_hold;
    logic        alt_go;
    logic        is_ack;
    logic        err;
    logic        more_beats;
    logic        rd_drive;
    logic        alt_last;

    // lock keeps the alternate master off until the final locked transfer
    assign alt_go     = alt_req && !lock_hold && !bus_gnt && !owned_in
                        && (state == ST_IDLE);
    assign is_ack     = (cur.cls == CLS_ACK);
    assign err        = !is_ack && (cur_addr[31:AW+2] != '0) && !cur_addr[NOCACHE_BIT];
    assign more_beats = (cur.size == SZ_LINE) && !cur_addr[NOBURST_BIT]
                        && (beats_left != 2'h0) && !err;
    assign rd_drive   = (state == ST_RESP) && cur.rd && !err;
    assign alt_last   = (state == ST_ALT) && (alt_cnt == 2'h0);

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_IDLE;
        end else if (bclk_en) begin
            unique case (state)
                ST_IDLE: begin
                    if (alt_go) begin
                        state <= ST_ALT;
                    end else if (xfer_start && bus_gnt) begin
                        state <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (wait_cnt == 2'h0) begin
                        state <= ST_RESP;
                    end
                end
                ST_RESP: begin
                    if (!more_beats) begin
                        state <= ST_IDLE;
                    end
                end
                ST_ALT: begin
                    if (alt_cnt == 2'h0) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // processor transfer capture and burst stepping
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cur        <= '0;
            cur_addr   <= '0;
            wait_cnt   <= '0;
            beats_left <= '0;
        end else if (bclk_en) begin
            if (state == ST_IDLE && !alt_go && xfer_start && bus_gnt) begin
                cur        <= attr;
                cur_addr   <= phys_addr_bus;
                wait_cnt   <= 2'(WAIT_BEATS - 1);
                beats_left <= 2'(LINE_BEATS - 1);
            end else if (state == ST_WAIT) begin
                wait_cnt <= wait_cnt - 1'b1;
            end else if (state == ST_RESP && more_beats) begin
                // line bursts wrap inside the 16-byte line
                cur_addr[3:2] <= cur_addr[3:2] + 1'b1;
                beats_left    <= beats_left - 1'b1;
            end
        end
    end

    // lock held from first locked transfer until the last one is answered
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            lock_hold <= 1'b0;
        end else if (bclk_en && state == ST_RESP && !more_beats) begin
            lock_hold <= cur.lock && !cur.lock_last;
        end
    end

    // ---------------------------------------------------------------
    // slave answer
    // ---------------------------------------------------------------
    assign xfer_ack        = (state == ST_RESP) && !err;
    assign xfer_err_ack    = (state == ST_RESP) && err;
    assign data_oe_n       = !rd_drive;
    assign slave_no_cache  = (state == ST_WAIT || state == ST_RESP)
                             && cur_addr[NOCACHE_BIT];
    assign slave_no_burst  = (state == ST_WAIT || state == ST_RESP)
                             && (cur.size == SZ_LINE) && cur_addr[NOBURST_BIT];
    assign auto_vector_req = (state == ST_RESP) && is_ack && autovec_en;

    // latch clock rises one cycle into the beat and falls five cycles in, so the processor sees settled data
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            read_latch_clk <= 1'b0;
        end else begin
            read_latch_clk <= dle_mode && rd_drive && !div_cnt[DIV_W-1];
        end
    end

    // ---------------------------------------------------------------
    // memory port, shared by processor and alternate master
    // ---------------------------------------------------------------
    logic [AW-1:0] mem_addr;
    logic          mem_rd;
    logic          mem_wr;
    logic [3:0]    mem_lanes;
    logic [31:0]   mem_wdata;
    logic          alt_rd_pend;

    always_comb begin
        mem_addr  = cur_addr[AW+1:2];
        mem_rd    = 1'b0;
        mem_wr    = 1'b0;
        mem_lanes = cebi_lanes(cur.size, cur_addr[1:0]);
        mem_wdata = data_in;
        if (state == ST_ALT) begin
            mem_addr  = alt_cur.addr[AW+1:2];
            mem_lanes = 4'hf;
            mem_wdata = alt_wd;
            mem_rd    = bclk_en && alt_last && alt_cur.rd && !alt_inhibited;
            mem_wr    = bclk_en && alt_last && !alt_cur.rd && !alt_inhibited;
        end else if (state == ST_WAIT) begin
            mem_rd = cur.rd && !err && !is_ack;
        end else if (state == ST_RESP && bclk_en) begin
            mem_wr = !cur.rd && !err && !is_ack;
            // fetch the next burst word ahead of its beat
            mem_rd = cur.rd && more_beats;
            if (more_beats) begin
                mem_addr[1:0] = cur_addr[3:2] + 1'b1;
            end
        end
    end

    cebi_mem #(.AW(AW)) u_mem (
        .core_clk (core_clk),
        .addr     (mem_addr),
        .rd_en    (mem_rd),
        .wr_en    (mem_wr),
        .lanes    (mem_lanes),
        .wdata    (mem_wdata),
        .rdata    (data_out)
    );

    // ---------------------------------------------------------------
    // arbiter and alternate master
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_gnt <= 1'b0;
        end else if (bclk_en) begin
            // alternate master wins unless a locked sequence is open
            bus_gnt <= lock_hold || (bus_req && !alt_req && state != ST_ALT);
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            alt_cur       <= '0;
            alt_wd        <= '0;
            alt_cnt       <= '0;
            alt_inhibited <= 1'b0;
            alt_start     <= 1'b0;
        end else if (bclk_en) begin
            alt_start <= alt_go;
            if (alt_go) begin
                alt_cur       <= alt_cmd;
                alt_wd        <= alt_wdata;
                alt_cnt       <= 2'(ALT_BEATS - 1);
                alt_inhibited <= 1'b0;
            end else if (state == ST_ALT) begin
                alt_cnt       <= alt_cnt - 1'b1;
                alt_inhibited <= alt_inhibited || mem_hold_off;
            end
        end
    end

    assign owned_out  = 1'b1;
    assign owned_oe_n = (state != ST_ALT);
    assign snoop_op   = (state == ST_ALT) ? alt_cur.op : 2'h0;
    assign snoop_addr = alt_cur.addr;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            alt_rd_pend <= 1'b0;
            alt_done    <= 1'b0;
            alt_rdata   <= '0;
        end else begin
            alt_rd_pend <= bclk_en && alt_last;
            alt_done    <= alt_rd_pend;
            if (alt_rd_pend && alt_cur.rd) begin
                alt_rdata <= data_out;
            end
        end
    end

    // ---------------------------------------------------------------
    // side controls, reset and interrupts
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            caches_off   <= 1'b0;
            xlate_off    <= 1'b0;
            cpu_reset_in <= 1'b1;
            periph_reset <= 1'b0;
            irq_seen     <= 1'b0;
        end else begin
            caches_off   <= cache_kill;
            xlate_off    <= xlate_kill;
            cpu_reset_in <= sys_reset_req;
            periph_reset <= ext_reset_out || sys_reset_req;
            irq_seen     <= irq_waiting;
        end
    end

    // highest pending source wins the encoded level
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_level <= 3'h0;
        end else begin
            irq_level <= 3'h0;
            for (int i = 1; i <= 7; i++) begin
                if (irq_src[i]) begin
                    irq_level <= 3'(i);
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence s_start_taken;
        bclk_en && state == ST_IDLE && !alt_go && xfer_start && bus_gnt;
    endsequence

    sequence s_answered;
        xfer_ack || xfer_err_ack;
    endsequence

    AST_ACK_EXCL: assert property (!(xfer_ack && xfer_err_ack))
        else $error("ack and error ack together");
    AST_ACK_AFTER_START: assert property (s_start_taken |-> ##[8:16] s_answered)
        else $error("transfer not answered in time");
    AST_DRIVE_READ: assert property (!data_oe_n |-> xfer_ack && cur.rd)
        else $error("data driven outside a read answer");
    AST_LANES: assert property (xfer_ack && cur.size == SZ_BYTE |-> $onehot(mem_lanes))
        else $error("byte transfer not on one lane");
    AST_NOBURST: assert property (slave_no_burst |-> cur.size == SZ_LINE && !more_beats)
        else $error("burst continued after inhibit");
    AST_CLK_RATIO: assert property ($changed(bclk_out) |-> $changed(pclk_out))
        else $error("processor clock not twice bus clock");
    AST_PCLK_PERIOD: assert property ($rose(pclk_out) |-> ##4 $rose(pclk_out))
        else $error("processor clock period wrong");
    AST_GNT_ALT: assert property (state == ST_ALT |-> !bus_gnt)
        else $error("grant held during alternate master access");
    AST_OWNED: assert property (state == ST_ALT |-> !owned_oe_n && owned_out)
        else $error("bus owned not driven by alternate master");
    AST_SNOOP: assert property (alt_start |-> snoop_op == alt_cur.op)
        else $error("snoop code not shown with alternate start");
    AST_AUTO_VECTOR_REQ: assert property (auto_vector_req |-> is_ack && xfer_ack)
        else $error("autovector outside acknowledge transfer");
    AST_DLE: assert property (read_latch_clk |-> $past(dle_mode) && $past(rd_drive))
        else $error("latch clock without latch mode read");

endmodule

// ===== sim/cebi_cpu.sv
// Purpose: processor model facing the bus host
// Assumes: host samples pins on its bus clock enable
// Notes:   lock bits come from the caller, plain by default
`timescale 1ns/1ps
module cebi_cpu
    import cebi_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        bclk_out,
    output logic      [31:0] phys_addr_bus,
    output cebi_attr_s       attr,
    output logic             xfer_start,
    output logic             xfer_active,
    output logic      [31:0] data_in,
    input  wire logic [31:0] data_out,
    input  wire logic        data_oe_n,
    input  wire logic        xfer_ack,
    input  wire logic        xfer_err_ack,
    input  wire logic        slave_no_cache,
    input  wire logic        slave_no_burst,
    input  wire logic        read_latch_clk,
    input  wire logic        auto_vector_req,
    input  wire logic        bus_gnt,
    output logic             bus_req,
    input  wire logic        alt_start,
    input  wire logic [1:0]  snoop_op,
    output logic             mem_hold_off
);
    // ------------------------------------------------------------
    // bus master
    // ------------------------------------------------------------
    logic [31:0] beat_data [0:3];
    logic [31:0] dle_data;
    logic        snoop_hit, got_err, seen_nc, seen_nb, seen_av, oe_ok;
    int          lat, beats;

    initial begin
        phys_addr_bus = '0;
        attr = '0;
        xfer_start = 1'b0;
        xfer_active = 1'b0;
        data_in = '0;
        bus_req = 1'b0;
        snoop_hit = 1'b0;
    end

    // only the first snooped beat, so memory is stopped before it commits
    assign mem_hold_off = snoop_hit & alt_start & (snoop_op != 2'h0);
    // falling edge, so the data has settled for a whole half beat
    always @(negedge read_latch_clk) dle_data = data_out;

    always @(negedge core_clk) if (xfer_active) begin
        got_err |= (xfer_err_ack === 1'b1);
        seen_nc |= (slave_no_cache === 1'b1);
        seen_nb |= (slave_no_burst === 1'b1);
        seen_av |= (auto_vector_req === 1'b1);
        if (attr.rd && xfer_ack === 1'b1 && data_oe_n !== 1'b0) oe_ok = 1'b0;
    end

    task automatic xfer(input logic [31:0] a, input logic [1:0] cls, input logic [1:0] sz,
                        input logic rd, input logic [31:0] wd, input logic [1:0] lk = 2'h0);
        int n;
        n = 0;
        bus_req = 1'b1;
        while (bus_gnt !== 1'b1 && n < 40) begin
            @(negedge core_clk);
            n++;
        end
        @(negedge bclk_out);
        {got_err, seen_nc, seen_nb, seen_av, oe_ok} = 5'h01;
        lat = 0;
        @(negedge core_clk);
        phys_addr_bus = a;
        attr = '{cls, 3'h0, 2'h1, 2'h2, sz, rd, lk[1], lk[0], a[31]};
        data_in = wd;
        xfer_start = 1'b1;
        xfer_active = 1'b1;
        @(negedge bclk_out);
        do begin
            @(negedge core_clk);
            xfer_start = 1'b0;
            lat++;
        end while (xfer_ack !== 1'b1 && xfer_err_ack !== 1'b1 && lat < 40);
        for (n = 0; n < 40 && (xfer_ack === 1'b1 || xfer_err_ack === 1'b1); n++) begin
            if (n % 8 == 0) beat_data[(n / 8) % 4] = data_out;
            @(negedge core_clk);
        end
        beats = n / 8;
        xfer_active = 1'b0;
        bus_req = 1'b0;
        data_in = ~wd;
        @(negedge core_clk);
    endtask
endmodule

// ===== sim/tb_cebi_host.sv
// Purpose: self-checking bench for the bus host
// Assumes: cebi_cpu plays the processor
// Notes:   lane expectations are big-endian
`timescale 1ns/1ps
module tb_cebi_host
    import cebi_pkg::*;
;
    logic        core_clk, reset_n, pclk_out, bclk_out, xfer_start, xfer_active, data_oe_n;
    logic        xfer_ack, xfer_err_ack, slave_no_cache, slave_no_burst, dle_mode;
    logic        read_latch_clk, bus_req, bus_gnt, owned_in, owned_out, owned_oe_n, alt_start;
    logic        mem_hold_off, alt_req, alt_done, alt_inhibited, cache_kill, xlate_kill;
    logic        caches_off, xlate_off, sys_reset_req, cpu_reset_in, ext_reset_out;
    logic        periph_reset, irq_waiting, irq_seen, autovec_en, auto_vector_req;
    logic [31:0] phys_addr_bus, data_in, data_out, snoop_addr, alt_wdata, alt_rdata;
    logic [1:0]  snoop_op;
    logic [7:1]  irq_src;
    logic [2:0]  irq_level;
    cebi_attr_s  attr;
    cebi_alt_s   alt_cmd;
    int          fail_count, check_count;

    // ------------------------------------------------------------
    // wiring
    // ------------------------------------------------------------
    assign owned_in = xfer_active | (owned_oe_n === 1'b0 && owned_out === 1'b1);

    cebi_host i_cebi_host (
        .core_clk, .reset_n, .pclk_out, .bclk_out, .phys_addr_bus, .attr, .xfer_start,
        .xfer_active, .data_in, .data_out, .data_oe_n, .xfer_ack, .xfer_err_ack,
        .slave_no_cache, .slave_no_burst, .dle_mode, .read_latch_clk, .bus_req, .bus_gnt,
        .owned_in, .owned_out, .owned_oe_n, .snoop_op, .snoop_addr, .alt_start,
        .mem_hold_off, .alt_req, .alt_cmd, .alt_wdata, .alt_done, .alt_inhibited,
        .alt_rdata, .cache_kill, .xlate_kill, .caches_off, .xlate_off, .sys_reset_req,
        .cpu_reset_in, .ext_reset_out, .periph_reset, .irq_src, .irq_level, .irq_waiting,
        .irq_seen, .autovec_en, .auto_vector_req
    );
    cebi_cpu i_cebi_cpu (
        .core_clk, .bclk_out, .phys_addr_bus, .attr, .xfer_start, .xfer_active, .data_in,
        .data_out, .data_oe_n, .xfer_ack, .xfer_err_ack, .slave_no_cache, .slave_no_burst,
        .read_latch_clk, .auto_vector_req, .bus_gnt, .bus_req, .alt_start, .snoop_op,
        .mem_hold_off
    );

    always #2.5 core_clk = ~core_clk;

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_lanes;
        i_cebi_cpu.xfer(32'h20, CLS_NORMAL, SZ_LONG, 1'b0, 32'h11223344);
        i_cebi_cpu.xfer(32'h21, CLS_NORMAL, SZ_BYTE, 1'b0, 32'haaaaaaaa);
        i_cebi_cpu.xfer(32'h22, CLS_NORMAL, SZ_WORD, 1'b0, 32'hbbbbbbbb);
        for (int c = 0; c < 3; c++) begin
            i_cebi_cpu.xfer(32'h20, 2'(c), SZ_LONG, 1'b1, 32'h0);
            check("lanes", 32'h11aabbbb, i_cebi_cpu.beat_data[0]);
            check("delay", 32'(WAIT_BEATS * BCLK_CYC + 1), 32'(i_cebi_cpu.lat));
            check("drive", 32'h1, 32'(i_cebi_cpu.oe_ok));
            check("nocache", 32'h0, 32'(i_cebi_cpu.seen_nc));
        end
    endtask

    task automatic t_errors;
        i_cebi_cpu.xfer(32'h00010000, CLS_NORMAL, SZ_LONG, 1'b1, 32'h0);
        check("err", 32'h1, 32'(i_cebi_cpu.got_err));
        i_cebi_cpu.xfer(32'h80010000, CLS_NORMAL, SZ_LONG, 1'b1, 32'h0);
        check("region err", 32'h0, 32'(i_cebi_cpu.got_err));
        check("nocache", 32'h1, 32'(i_cebi_cpu.seen_nc));
    endtask

    task automatic t_line;
        for (int i = 0; i < 4; i++) begin
            i_cebi_cpu.xfer(32'h30 + 32'(4 * i), CLS_NORMAL, SZ_LONG, 1'b0, 32'h50000000 + 32'(i));
        end
        dle_mode = 1'b1;
        i_cebi_cpu.xfer(32'h38, CLS_NORMAL, SZ_LINE, 1'b1, 32'h0);
        check("beats", 32'h4, 32'(i_cebi_cpu.beats));
        for (int k = 0; k < 4; k++) begin
            check("wrap", 32'h50000000 + 32'((k + 2) % 4), i_cebi_cpu.beat_data[k]);
        end
        check("latch", 32'h50000001, i_cebi_cpu.dle_data);
        check("burst ok", 32'h0, 32'(i_cebi_cpu.seen_nb));
        dle_mode = 1'b0;
        i_cebi_cpu.xfer(32'hc0000038, CLS_NORMAL, SZ_LINE, 1'b1, 32'h0);
        check("noburst", 32'h1, 32'(i_cebi_cpu.seen_nb));
    endtask

    task automatic t_irq;
        autovec_en = 1'b1;
        irq_src = 7'h14;
        irq_waiting = 1'b1;
        i_cebi_cpu.xfer(32'h00010000, CLS_ACK, SZ_BYTE, 1'b1, 32'h0);
        check("level", 32'h5, 32'(irq_level));
        check("pending", 32'h1, 32'(irq_seen));
        check("ack err", 32'h0, 32'(i_cebi_cpu.got_err));
        check("autovec", 32'h1, 32'(i_cebi_cpu.seen_av));
        irq_src = 7'h01;
        irq_waiting = 1'b0;
        autovec_en = 1'b0;
        repeat (3) @(negedge core_clk);
        check("level", 32'h1, 32'(irq_level));
        check("pending", 32'h0, 32'(irq_seen));
    endtask

    task automatic alt_go(input cebi_alt_s c, input logic [31:0] wd, output logic own);
        int n;
        own = 1'b0;
        alt_cmd = c;
        alt_wdata = wd;
        alt_req = 1'b1;
        for (n = 0; n < 80 && alt_done !== 1'b1; n++) begin
            @(negedge core_clk);
            if (owned_oe_n === 1'b0 && owned_in === 1'b1 && snoop_op === c.op) own = 1'b1;
        end
        alt_req = 1'b0;
        check("alt done", 32'h1, 32'(alt_done));
        @(negedge core_clk);
    endtask

    task automatic t_alt;
        logic own;
        for (int op = 0; op < 4; op++) begin
            alt_go('{32'h20, 2'(op), 1'b1}, 32'h0, own);
            check("alt rd", 32'h11aabbbb, alt_rdata);
            check("owner", 32'h1, 32'(own));
        end
        i_cebi_cpu.snoop_hit = 1'b1;
        alt_go('{32'h20, 2'h1, 1'b0}, 32'hdeadbeef, own);
        check("inhibit", 32'h1, 32'(alt_inhibited));
        i_cebi_cpu.snoop_hit = 1'b0;
        alt_go('{32'h24, 2'h1, 1'b0}, 32'hcafef00d, own);
        check("inhibit", 32'h0, 32'(alt_inhibited));
        check("snoop addr", 32'h24, snoop_addr);
        i_cebi_cpu.xfer(32'h20, CLS_NORMAL, SZ_LONG, 1'b1, 32'h0, 2'h2);
        check("held", 32'h11aabbbb, i_cebi_cpu.beat_data[0]);
        repeat (16) @(negedge core_clk);
        check("lock gnt", 32'h1, 32'(bus_gnt));
        i_cebi_cpu.xfer(32'h24, CLS_NORMAL, SZ_LONG, 1'b1, 32'h0, 2'h3);
        check("alt wr", 32'hcafef00d, i_cebi_cpu.beat_data[0]);
    endtask

    task automatic t_side;
        cache_kill = 1'b1;
        xlate_kill = 1'b1;
        ext_reset_out = 1'b1;
        sys_reset_req = 1'b1;
        repeat (2) @(negedge core_clk);
        check("caches", 32'h1, 32'(caches_off));
        check("xlate", 32'h1, 32'(xlate_off));
        check("periph", 32'h1, 32'(periph_reset));
        check("cpu reset", 32'h1, 32'(cpu_reset_in));
        cache_kill = 1'b0;
        xlate_kill = 1'b0;
        ext_reset_out = 1'b0;
        sys_reset_req = 1'b0;
        repeat (2) @(negedge core_clk);
        check("caches", 32'h0, 32'(caches_off));
        check("xlate", 32'h0, 32'(xlate_off));
        check("periph", 32'h0, 32'(periph_reset));
        check("cpu reset", 32'h0, 32'(cpu_reset_in));
    endtask

    task automatic complete_run;
        $display("checks %0d errors %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        {core_clk, reset_n, dle_mode, alt_req, cache_kill, xlate_kill} = 6'h0;
        {sys_reset_req, ext_reset_out, irq_waiting, autovec_en} = 4'h0;
        {alt_cmd, alt_wdata, irq_src} = '0;
        repeat (10) @(negedge core_clk);
        reset_n = 1'b1;
        t_lanes();
        t_errors();
        t_line();
        t_irq();
        t_alt();
        t_side();
        complete_run();
    end

    // transfers take about a thousand core cycles in all, far below this span
    initial begin
        #60000;
        fail_count++;
        complete_run();
    end
endmodule
